// file: pkg/kpsc_pkg.sv
package kpsc_pkg;

   // register pages and addresses
   localparam logic [3:0]  PAGE_DATA             = 4'h0;
   localparam logic [3:0]  PAGE_CTRL             = 4'h1;
   localparam logic [5:0]  ADDR_KEY_DATA         = 6'h04;
   localparam logic [5:0]  ADDR_KEYPAD_CONTROL   = 6'h01;
   localparam logic [5:0]  ADDR_SOFT_RESET       = 6'h04;
   localparam logic [5:0]  ADDR_SECONDARY_CONFIG = 6'h06;
   localparam logic [5:0]  ADDR_KEY_MASK         = 6'h10;
   localparam logic [15:0] SOFT_RESET_CODE       = 16'hBB00;

   // serial command word layout
   localparam int CMD_RW_BIT   = 15;
   localparam int CMD_PAGE_LSB = 11;
   localparam int CMD_ADDR_LSB = 5;

   // field positions
   localparam int BIT_KEY_PRESSED    = 15;
   localparam int BIT_SCAN_BUSY_STOP = 14;
   localparam int DEBOUNCE_SEL_LSB   = 11;
   localparam int BIT_IRQ_REL_HI     = 15;
   localparam int BIT_IRQ_REL_LO     = 14;

   // reset values
   localparam logic [2:0]  RST_DEBOUNCE_SEL    = 3'h0;
   localparam logic [1:0]  RST_IRQ_RELEASE_SEL = 2'h3;
   localparam logic [15:0] RST_KEY_MASK        = 16'h0000;
   localparam logic [15:0] RST_KEY_DATA        = 16'h0000;

   // interrupt release selections
   localparam logic [1:0] REL_KEY_UP    = 2'h0;
   localparam logic [1:0] REL_STOP_ONLY = 2'h1;
   localparam logic [1:0] REL_ALL       = 2'h2;
   localparam logic [1:0] REL_DATA_READ = 2'h3;

   // timing
   localparam int CLK_PERIOD_PS     = 4000;
   localparam int MS_PS             = 1000000000;
   localparam int MS_CYCLES         = MS_PS / CLK_PERIOD_PS;
   localparam int ROW_SETTLE_NS     = 16;
   localparam int ROW_SETTLE_CYCLES =
      (ROW_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SYNC_STAGES       = 2;
   localparam logic [6:0] DEBOUNCE_MS_TABLE [0:7] = '{
      7'h02, 7'h0A, 7'h14, 7'h32, 7'h3C, 7'h50, 7'h64, 7'h78};

endpackage : kpsc_pkg

// file: logic/kpsc_spi_port.sv
`timescale 1ns/1ps
module kpsc_spi_port
   import kpsc_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // serial pins
   input  wire logic        spiSclk,
   input  wire logic        spiCsN,
   input  wire logic        spiMosi,
   output logic             spiMiso,
   output logic             spiMisoOe,
   // register access
   output logic             regWrite,
   output logic             regRead,
   output logic [3:0]       regPage,
   output logic [5:0]       regAddr,
   output logic [15:0]      regWdata,
   input  wire logic [15:0] regRdata
);

   logic [2:0]  syncA;
   logic [2:0]  syncB;
   logic        sclkPrev;
   logic [5:0]  bitCnt;
   logic [15:0] shiftIn;
   logic [15:0] shiftOut;
   logic        isRead;
   logic        loadPend;
   logic [5:0]  next_bitCnt;
   logic [15:0] next_shiftIn;
   logic [15:0] next_shiftOut;
   logic        next_isRead;
   logic        next_loadPend;
   logic        next_regWrite;
   logic        next_regRead;
   logic [3:0]  next_regPage;
   logic [5:0]  next_regAddr;
   logic [15:0] next_regWdata;

   // pins are asynchronous: sclk must run at most clk/8
   always_ff @(posedge clk) begin
      syncA <= {spiMosi, spiCsN, spiSclk};
      syncB <= syncA;
   end

   always_comb begin
      logic [15:0] word;
      logic        rise;
      logic        fall;
      word          = {shiftIn[14:0], syncB[2]};
      rise          = syncB[0] & ~sclkPrev;
      fall          = ~syncB[0] & sclkPrev;
      next_bitCnt   = bitCnt;
      next_shiftIn  = shiftIn;
      next_shiftOut = shiftOut;
      next_isRead   = isRead;
      next_loadPend = 1'b0;
      next_regWrite = 1'b0;
      next_regRead  = 1'b0;
      next_regPage  = regPage;
      next_regAddr  = regAddr;
      next_regWdata = regWdata;
      if (syncB[1]) begin
         next_bitCnt = 6'h00;
         next_isRead = 1'b0;
      end else begin
         if (loadPend) begin
            next_shiftOut = regRdata;
         end
         if (rise && bitCnt < 6'h20) begin
            next_shiftIn = word;
            next_bitCnt  = bitCnt + 6'h01;
            if (bitCnt == 6'h0F) begin
               next_isRead   = word[CMD_RW_BIT];
               next_regPage  = word[CMD_PAGE_LSB +: 4];
               next_regAddr  = word[CMD_ADDR_LSB +: 6];
               next_regRead  = word[CMD_RW_BIT];
               next_loadPend = word[CMD_RW_BIT];
            end
            if (bitCnt == 6'h1F && !isRead) begin
               next_regWrite = 1'b1;
               next_regWdata = word;
            end
         end
         if (fall && isRead && bitCnt > 6'h10) begin
            next_shiftOut = {shiftOut[14:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sclkPrev  <= 1'b0;
         bitCnt    <= 6'h00;
         shiftIn   <= 16'h0000;
         shiftOut  <= 16'h0000;
         isRead    <= 1'b0;
         loadPend  <= 1'b0;
         regWrite  <= 1'b0;
         regRead   <= 1'b0;
         regPage   <= 4'h0;
         regAddr   <= 6'h00;
         regWdata  <= 16'h0000;
         spiMiso   <= 1'b0;
         spiMisoOe <= 1'b0;
      end else begin
         sclkPrev  <= syncB[0];
         bitCnt    <= next_bitCnt;
         shiftIn   <= next_shiftIn;
         shiftOut  <= next_shiftOut;
         isRead    <= next_isRead;
         loadPend  <= next_loadPend;
         regWrite  <= next_regWrite;
         regRead   <= next_regRead;
         regPage   <= next_regPage;
         regAddr   <= next_regAddr;
         regWdata  <= next_regWdata;
         spiMiso   <= next_shiftOut[15];
         spiMisoOe <= ~syncB[1];
      end
   end

endmodule : kpsc_spi_port

// file: logic/kpsc_keypad_scan_control.sv
`timescale 1ns/1ps
// Operation
// - key_pressed_flag goes high once debounced, inverse of irq pin, reset 0.
// - scan_busy_stop reads 0 while scanning or debouncing, 1 when idle.
// - writing 0 to scan_busy_stop keeps scanning until key release or stop.
// - writing 1 to scan_busy_stop halts scanning at once, even key held.
// - debounce_select codes 0..7 pick 2,10,20,50,60,80,100,120 ms; reset 0.
// - a key with its mask bit set is not detected by scans.
// - a lone masked key never raises the keypad interrupt.
// - the key mask resets to all zeros.
// - row r, column c maps to bit 4*(r-1)+(c-1).
// - each scan reports every pressed key in one data word.
// - three rectangle corners pressed may also report the fourth corner.
// - result_ready_status mirrors result_ready_n; low on new data.
// - secondary config writes store bits 15:14 as irq release select.
// - keypad_irq_n is active low and holds until an enabled release event.
// - hardware reset or writing BB00h to page 1 address 04h releases irq.
// - stop write, key release and data register read are release events.
// - release select 00:A/B/C, 01:A/B, 10:all, 11:A/B/D, reset 11.
module kpsc_keypad_scan_control
   import kpsc_pkg::*;
#(
   parameter int MS_TICK_CYCLES = MS_CYCLES
)
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // serial host port
   input  wire logic       spiSclk,
   input  wire logic       spiCsN,
   input  wire logic       spiMosi,
   output logic            spiMiso,
   output logic            spiMisoOe,
   // keypad matrix
   output logic [3:0]      rowDriveN,
   input  wire logic [3:0] colSenseN,
   // result and interrupt pins
   input  wire logic       touchDataPending,
   output logic            resultReadyN,
   output logic            keypadIrqN
);

   localparam int          MSW    = $clog2(MS_TICK_CYCLES);
   localparam logic [3:0]  SAMPLE = 4'(ROW_SETTLE_CYCLES + SYNC_STAGES);

   typedef enum logic [1:0] {
      ST_IDLE, ST_DEBOUNCE, ST_HOLD, ST_WAIT_RELEASE
   } kpsc_state_e;

   function automatic logic hit(input logic [3:0] page,
                                input logic [5:0] addr,
                                input logic [3:0] p,
                                input logic [5:0] a);
      hit = (page == p) && (addr == a);
   endfunction : hit

   function automatic logic [3:0] rowPattern(input kpsc_state_e st,
                                             input logic [1:0]  row);
      if (st == ST_DEBOUNCE || st == ST_HOLD) begin
         rowPattern = ~(4'h1 << row);
      end else begin
         rowPattern = 4'h0;
      end
   endfunction : rowPattern

   // register port
   logic        regWrite;
   logic        regRead;
   logic [3:0]  regPage;
   logic [5:0]  regAddr;
   logic [15:0] regWdata;
   logic [15:0] regRdata;

   kpsc_spi_port u_spi (
      .clk       (clk),
      .rst       (rst),
      .spiSclk   (spiSclk),
      .spiCsN    (spiCsN),
      .spiMosi   (spiMosi),
      .spiMiso   (spiMiso),
      .spiMisoOe (spiMisoOe),
      .regWrite  (regWrite),
      .regRead   (regRead),
      .regPage   (regPage),
      .regAddr   (regAddr),
      .regWdata  (regWdata),
      .regRdata  (regRdata)
   );

   logic [3:0]     colA;
   logic [3:0]     colB;
   logic [MSW-1:0] msCnt;
   logic           msTick;
   kpsc_state_e    state;
   kpsc_state_e    next_state;
   logic [1:0]     scanRow;
   logic [1:0]     next_scanRow;
   logic [3:0]     settleCnt;
   logic [3:0]     next_settleCnt;
   logic [15:0]    scanWord;
   logic [15:0]    next_scanWord;
   logic [15:0]    lastWord;
   logic [15:0]    next_lastWord;
   logic [6:0]     dbCnt;
   logic [6:0]     next_dbCnt;
   logic [2:0]     debounceSelect;
   logic [2:0]     next_debounceSelect;
   logic [1:0]     irqReleaseSel;
   logic [1:0]     next_irqReleaseSel;
   logic [15:0]    keyMask;
   logic [15:0]    next_keyMask;
   logic [15:0]    keyData;
   logic [15:0]    next_keyData;
   logic           keyNew;
   logic           next_keyNew;
   logic           irqActive;
   logic           next_irqActive;
   logic           busy;
   logic           anyKey;
   logic           ctrlWrite;
   logic           stopEvt;
   logic           resumeEvt;
   logic           dataRead;
   logic           softRst;
   logic           irqSet;
   logic           keyUpEvt;
   logic           relEvt;

   // first stage feeds only the second
   always_ff @(posedge clk) begin
      colA <= colSenseN;
      colB <= colA;
   end

   // free-running millisecond timebase
   always_ff @(posedge clk) begin
      if (rst) begin
         msCnt <= '0;
      end else if (msCnt == MSW'(MS_TICK_CYCLES - 1)) begin
         msCnt <= '0;
      end else begin
         msCnt <= msCnt + 1'b1;
      end
   end
   assign msTick = (msCnt == MSW'(MS_TICK_CYCLES - 1));

   assign busy      = (state == ST_DEBOUNCE) || (state == ST_HOLD);
   assign anyKey    = (colB != 4'hF);
   assign ctrlWrite = regWrite && hit(regPage, regAddr, PAGE_CTRL,
                                      ADDR_KEYPAD_CONTROL);
   assign stopEvt   = ctrlWrite && regWdata[BIT_SCAN_BUSY_STOP];
   assign resumeEvt = ctrlWrite && !regWdata[BIT_SCAN_BUSY_STOP];
   assign dataRead  = regRead && hit(regPage, regAddr, PAGE_DATA,
                                     ADDR_KEY_DATA);
   assign softRst   = regWrite && (regWdata == SOFT_RESET_CODE) &&
                      hit(regPage, regAddr, PAGE_CTRL, ADDR_SOFT_RESET);

   // register read answers
   always_comb begin
      regRdata = 16'h0000;
      if (hit(regPage, regAddr, PAGE_CTRL, ADDR_KEYPAD_CONTROL)) begin
         regRdata[BIT_KEY_PRESSED]    = irqActive;
         regRdata[BIT_SCAN_BUSY_STOP] = !busy;
         regRdata[DEBOUNCE_SEL_LSB +: 3] = debounceSelect;
      end else if (hit(regPage, regAddr, PAGE_CTRL,
                       ADDR_SECONDARY_CONFIG)) begin
         regRdata[BIT_IRQ_REL_HI] = resultReadyN;
         regRdata[BIT_IRQ_REL_LO] = irqReleaseSel[0];
      end else if (hit(regPage, regAddr, PAGE_CTRL, ADDR_KEY_MASK)) begin
         regRdata = keyMask;
      end else if (hit(regPage, regAddr, PAGE_DATA, ADDR_KEY_DATA)) begin
         regRdata = keyData;
      end
   end

   // scanner, debouncer and register state
   always_comb begin
      logic [15:0] capWord;
      logic [15:0] fullWord;
      capWord = scanWord;
      capWord[{scanRow, 2'b00} +: 4] = ~colB;
      // ghost keys on a rectangle's fourth corner pass through as seen
      fullWord = capWord & ~keyMask;
      next_state          = state;
      next_scanRow        = scanRow;
      next_settleCnt      = settleCnt;
      next_scanWord       = scanWord;
      next_lastWord       = lastWord;
      next_dbCnt          = dbCnt;
      next_debounceSelect = debounceSelect;
      next_irqReleaseSel  = irqReleaseSel;
      next_keyMask        = keyMask;
      next_keyData        = keyData;
      irqSet              = 1'b0;
      keyUpEvt            = 1'b0;
      if (settleCnt != SAMPLE) begin
         next_settleCnt = settleCnt + 4'h1;
      end
      case (state)
         ST_IDLE: begin
            if (settleCnt == SAMPLE && anyKey) begin
               next_state     = ST_DEBOUNCE;
               next_scanRow   = 2'h0;
               next_settleCnt = 4'h0;
               next_lastWord  = 16'h0000;
               next_dbCnt     = 7'h00;
            end
         end
         ST_DEBOUNCE, ST_HOLD: begin
            if (state == ST_DEBOUNCE && msTick && dbCnt != 7'h7F) begin
               next_dbCnt = dbCnt + 7'h01;
            end
            if (settleCnt == SAMPLE) begin
               next_settleCnt = 4'h0;
               next_scanWord  = capWord;
               next_scanRow   = scanRow + 2'h1;
               if (scanRow == 2'h3) begin
                  if (fullWord == 16'h0000) begin
                     next_state = ST_IDLE;
                     keyUpEvt   = (state == ST_HOLD);
                  end else if (state == ST_DEBOUNCE) begin
                     if (fullWord != lastWord) begin
                        next_lastWord = fullWord;
                        next_dbCnt    = 7'h00;
                     end else if (dbCnt >
                                  DEBOUNCE_MS_TABLE[debounceSelect]) begin
                        // a whole tick past the target keeps it a least time
                        next_keyData = fullWord;
                        irqSet       = 1'b1;
                        next_state   = ST_HOLD;
                     end
                  end
               end
            end
         end
         ST_WAIT_RELEASE: begin
            if (settleCnt == SAMPLE && !anyKey) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (stopEvt) begin
         next_state     = ST_WAIT_RELEASE;
         next_settleCnt = 4'h0;
      end else if (resumeEvt && state == ST_WAIT_RELEASE) begin
         next_state     = ST_IDLE;
         next_settleCnt = 4'h0;
      end
      if (ctrlWrite) begin
         next_debounceSelect = regWdata[DEBOUNCE_SEL_LSB +: 3];
      end
      if (regWrite && hit(regPage, regAddr, PAGE_CTRL,
                          ADDR_SECONDARY_CONFIG)) begin
         next_irqReleaseSel = regWdata[BIT_IRQ_REL_LO +: 2];
      end
      if (regWrite && hit(regPage, regAddr, PAGE_CTRL, ADDR_KEY_MASK)) begin
         next_keyMask = regWdata;
      end
      if (softRst) begin
         next_state          = ST_IDLE;
         next_settleCnt      = 4'h0;
         next_debounceSelect = RST_DEBOUNCE_SEL;
         next_irqReleaseSel  = RST_IRQ_RELEASE_SEL;
         next_keyMask        = RST_KEY_MASK;
         next_keyData        = RST_KEY_DATA;
         irqSet              = 1'b0;
      end
   end

   // release events; a new press in the same cycle wins over any release but a soft reset
   always_comb begin
      relEvt = softRst || stopEvt;
      if (keyUpEvt && (irqReleaseSel == REL_KEY_UP ||
                       irqReleaseSel == REL_ALL)) begin
         relEvt = 1'b1;
      end
      if (dataRead && (irqReleaseSel == REL_ALL ||
                       irqReleaseSel == REL_DATA_READ)) begin
         relEvt = 1'b1;
      end
      next_irqActive = irqActive;
      if (irqSet) begin
         next_irqActive = 1'b1;
      end else if (relEvt) begin
         next_irqActive = 1'b0;
      end
      next_keyNew = keyNew;
      if (irqSet) begin
         next_keyNew = 1'b1;
      end else if (dataRead || softRst) begin
         next_keyNew = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state          <= ST_IDLE;
         scanRow        <= 2'h0;
         settleCnt      <= 4'h0;
         scanWord       <= 16'h0000;
         lastWord       <= 16'h0000;
         dbCnt          <= 7'h00;
         debounceSelect <= RST_DEBOUNCE_SEL;
         irqReleaseSel  <= RST_IRQ_RELEASE_SEL;
         keyMask        <= RST_KEY_MASK;
         keyData        <= RST_KEY_DATA;
         keyNew         <= 1'b0;
         irqActive      <= 1'b0;
         rowDriveN      <= 4'h0;
         resultReadyN   <= 1'b1;
         keypadIrqN     <= 1'b1;
      end else begin
         state          <= next_state;
         scanRow        <= next_scanRow;
         settleCnt      <= next_settleCnt;
         scanWord       <= next_scanWord;
         lastWord       <= next_lastWord;
         dbCnt          <= next_dbCnt;
         debounceSelect <= next_debounceSelect;
         irqReleaseSel  <= next_irqReleaseSel;
         keyMask        <= next_keyMask;
         keyData        <= next_keyData;
         keyNew         <= next_keyNew;
         irqActive      <= next_irqActive;
         rowDriveN      <= rowPattern(next_state, next_scanRow);
         resultReadyN   <= ~(next_keyNew | touchDataPending);
         keypadIrqN     <= ~next_irqActive;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_FLAG_INVERSE: assert property (
      regRead && hit(regPage, regAddr, PAGE_CTRL, ADDR_KEYPAD_CONTROL)
      |-> regRdata[BIT_KEY_PRESSED] == !keypadIrqN)
      else $error("pressed flag not inverse of irq pin");
   AST_BUSY_READ: assert property (
      (state == ST_IDLE) && hit(regPage, regAddr, PAGE_CTRL,
                                ADDR_KEYPAD_CONTROL)
      |-> regRdata[BIT_SCAN_BUSY_STOP])
      else $error("idle scanner reads busy");
   AST_STOP_HALTS: assert property (
      stopEvt |=> (state == ST_WAIT_RELEASE) && (rowDriveN == 4'h0))
      else $error("stop did not halt scanning");
   AST_MASKED_NO_IRQ: assert property (
      irqSet |-> (((lastWord & keyMask) == 16'h0000) &&
                  (lastWord != 16'h0000)) ##1 !keypadIrqN)
      else $error("irq raised for masked key");
   AST_MASK_RESET: assert property (
      $past(rst) |-> (keyMask == 16'h0000) && (irqReleaseSel == 2'h3))
      else $error("mask or release select wrong after reset");
   AST_IRQ_HOLDS: assert property (
      irqActive && !relEvt |=> irqActive && !keypadIrqN)
      else $error("irq released without enabled event");
   AST_SOFT_RESET: assert property (
      softRst |=> keypadIrqN && (keyMask == 16'h0000))
      else $error("soft reset did not clear irq and mask");
   AST_READ_RELEASE: assert property (
      dataRead && irqReleaseSel[1] && !irqSet |=> ##1 keypadIrqN)
      else $error("data read did not release irq");
   AST_READ_KEEPS: assert property (
      dataRead && (irqReleaseSel == REL_STOP_ONLY) && irqActive &&
      !stopEvt && !softRst |=> irqActive)
      else $error("data read released irq in stop-only mode");
   AST_READY_LOW: assert property (
      irqSet |=> !resultReadyN)
      else $error("result ready pin not low after new data");

   COV_IRQ: cover property (irqSet ##1 !keypadIrqN);
   COV_STOP_HOLD: cover property (state == ST_HOLD && stopEvt);
   COV_READ_REL: cover property (dataRead && irqActive ##1 !irqActive);
   COV_SOFT_RST: cover property (softRst && irqActive);

endmodule : kpsc_keypad_scan_control

// file: verification/kpsc_key_matrix.sv
`timescale 1ns/1ps
module kpsc_key_matrix (
   // matrix pins
   input  wire logic [3:0]  rowDriveN,
   output logic      [3:0]  colSenseN,
   // keys held by the bench
   input  wire logic [15:0] keysDown
);
   // pulled-up columns; ghost paths through undriven rows are not modelled
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         colSenseN[c] = 1'b1;
         for (int r = 0; r < 4; r++) begin
            if (!rowDriveN[r] && keysDown[4*r+c]) begin
               colSenseN[c] = 1'b0;
            end
         end
      end
   end
endmodule : kpsc_key_matrix

// file: verification/keypad_scan_control_tb.sv
`timescale 1ns/1ps
module keypad_scan_control_tb;
   import kpsc_pkg::*;
   logic        clk      = 1'b0;
   logic        rst      = 1'b1;
   logic        sclk     = 1'b0;
   logic        csN      = 1'b1;
   logic        mosi     = 1'b0;
   logic        miso;
   logic        readyN;
   logic        irqN;
   logic [3:0]  rowN;
   logic [3:0]  colN;
   logic [15:0] keysDown = 16'h0000;
   logic [15:0] rdData;
   logic        misoOe;
   logic        touchPend = 1'b0;
   int          failures = 0;
   int          n_checks = 0;

   always #2 clk = ~clk;

   kpsc_keypad_scan_control #(.MS_TICK_CYCLES(20)) u_dut (
      .clk(clk), .rst(rst), .spiSclk(sclk), .spiCsN(csN),
      .spiMosi(mosi), .spiMiso(miso), .spiMisoOe(misoOe),
      .rowDriveN(rowN), .colSenseN(colN), .touchDataPending(touchPend),
      .resultReadyN(readyN), .keypadIrqN(irqN));

   kpsc_key_matrix u_keys (
      .rowDriveN(rowN), .colSenseN(colN), .keysDown(keysDown));

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic close_out();
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // one framed command plus data word; sclk kept at clk/8
   task automatic xfer(input logic rw, input logic [3:0] pg,
                       input logic [5:0] ad, input logic [15:0] wd);
      logic [31:0] sh;
      sh = {rw, pg, ad, 5'h00, wd};
      csN = 1'b0;
      tick(4);
      check({15'h0, misoOe}, 16'h0001);
      for (int i = 31; i >= 0; i--) begin
         mosi = sh[i];
         sclk = 1'b0;
         tick(4);
         sclk = 1'b1;
         if (i < 16)
            rdData[i] = miso;
         tick(4);
      end
      sclk = 1'b0;
      tick(4);
      csN = 1'b1;
      tick(8);
   endtask : xfer

   task automatic wait_irq(input logic lvl);
      int k;
      k = 0;
      while (irqN !== lvl && k < 5000) begin
         tick(1);
         k++;
      end
      check({15'h0, irqN}, {15'h0, lvl});
      if (k >= 5000)
         close_out();
   endtask : wait_irq

   task automatic wait_idle();
      int k;
      k = 0;
      keysDown = 16'h0000;
      do begin
         xfer(1'b1, PAGE_CTRL, ADDR_KEYPAD_CONTROL, 16'h0000);
         k++;
      end while (!rdData[14] && k < 50);
      check({15'h0, rdData[14]}, 16'h0001);
      if (k >= 50)
         close_out();
   endtask : wait_idle

   initial begin
      tick(16);
      rst = 1'b0;
      tick(4);
      check({11'h0, rowN, misoOe}, 16'h0000);
      xfer(1'b1, PAGE_CTRL, ADDR_KEYPAD_CONTROL, 16'h0000);
      check(rdData & 16'hF800, 16'h4000);
      xfer(1'b1, PAGE_CTRL, ADDR_SECONDARY_CONFIG, 16'h0000);
      check(rdData & 16'hC000, 16'hC000);
      xfer(1'b1, PAGE_CTRL, ADDR_KEY_MASK, 16'h0000);
      check(rdData, 16'h0000);
      touchPend = 1'b1;
      xfer(1'b1, PAGE_CTRL, ADDR_SECONDARY_CONFIG, 16'h0000);
      check({14'h0, rdData[15], readyN}, 16'h0000);
      touchPend = 1'b0;
      tick(2);
      check({15'h0, readyN}, 16'h0001);
      // ends on code 0 so the later debounce windows stay short
      for (int d = 7; d >= 0; d--) begin
         xfer(1'b0, PAGE_CTRL, ADDR_KEYPAD_CONTROL, 16'(d) << 11);
         xfer(1'b1, PAGE_CTRL, ADDR_KEYPAD_CONTROL, 16'h0000);
         check(rdData & 16'h3800, 16'(d) << 11);
      end
      keysDown = 16'h2140;
      tick(40);
      check({15'h0, irqN}, 16'h0001);
      wait_irq(1'b0);
      check({15'h0, readyN}, 16'h0000);
      xfer(1'b1, PAGE_CTRL, ADDR_KEYPAD_CONTROL, 16'h0000);
      check(rdData & 16'hC000, 16'h8000);
      xfer(1'b1, PAGE_CTRL, ADDR_SECONDARY_CONFIG, 16'h0000);
      check(rdData & 16'h8000, 16'h0000);
      xfer(1'b1, PAGE_DATA, ADDR_KEY_DATA, 16'h0000);
      check(rdData, 16'h2140);
      check({14'h0, irqN, readyN}, 16'h0003);
      wait_idle();
      xfer(1'b0, PAGE_CTRL, ADDR_KEY_MASK, 16'h0002);
      keysDown = 16'h0002;
      tick(600);
      check({15'h0, irqN}, 16'h0001);
      keysDown = 16'h0003;
      wait_irq(1'b0);
      xfer(1'b1, PAGE_DATA, ADDR_KEY_DATA, 16'h0000);
      check(rdData, 16'h0001);
      wait_idle();
      xfer(1'b0, PAGE_CTRL, ADDR_SECONDARY_CONFIG, 16'h4000);
      keysDown = 16'h8000;
      wait_irq(1'b0);
      xfer(1'b1, PAGE_DATA, ADDR_KEY_DATA, 16'h0000);
      check({rdData[15:1], irqN}, 16'h8000);
      keysDown = 16'h0000;
      tick(300);
      check({15'h0, irqN}, 16'h0000);
      xfer(1'b0, PAGE_CTRL, ADDR_KEYPAD_CONTROL, 16'h4000);
      check({15'h0, irqN}, 16'h0001);
      xfer(1'b0, PAGE_CTRL, ADDR_KEYPAD_CONTROL, 16'h0000);
      xfer(1'b0, PAGE_CTRL, ADDR_SECONDARY_CONFIG, 16'h0000);
      keysDown = 16'h0020;
      wait_irq(1'b0);
      xfer(1'b0, PAGE_CTRL, ADDR_KEYPAD_CONTROL, 16'h4000);
      xfer(1'b1, PAGE_CTRL, ADDR_KEYPAD_CONTROL, 16'h0000);
      check({10'h0, rdData[14], irqN, rowN}, 16'h0030);
      wait_idle();
      xfer(1'b0, PAGE_CTRL, ADDR_KEYPAD_CONTROL, 16'h0000);
      keysDown = 16'h0020;
      wait_irq(1'b0);
      keysDown = 16'h0000;
      wait_irq(1'b1);
      xfer(1'b0, PAGE_CTRL, ADDR_SECONDARY_CONFIG, 16'h8000);
      keysDown = 16'h0400;
      wait_irq(1'b0);
      xfer(1'b1, PAGE_DATA, ADDR_KEY_DATA, 16'h0000);
      check({rdData[15:1], irqN}, 16'h0401);
      wait_idle();
      keysDown = 16'h0001;
      wait_irq(1'b0);
      xfer(1'b0, PAGE_CTRL, ADDR_SOFT_RESET, SOFT_RESET_CODE);
      check({15'h0, irqN}, 16'h0001);
      xfer(1'b1, PAGE_CTRL, ADDR_KEY_MASK, 16'h0000);
      check(rdData, 16'h0000);
      // the held key is found again; select 11 lets the read free the irq
      xfer(1'b1, PAGE_DATA, ADDR_KEY_DATA, 16'h0000);
      check({rdData[15:1], irqN}, 16'h0001);
      wait_idle();
      xfer(1'b0, PAGE_CTRL, ADDR_KEYPAD_CONTROL, 16'h0800);
      keysDown = 16'h0001;
      tick(200);
      check({15'h0, irqN}, 16'h0001);
      wait_irq(1'b0);
      rst = 1'b1;
      keysDown = 16'h0000;
      tick(2);
      rst = 1'b0;
      tick(1);
      check({11'h0, rowN, irqN}, 16'h0001);
      tick(3);
      xfer(1'b1, PAGE_CTRL, ADDR_KEYPAD_CONTROL, 16'h0000);
      check(rdData & 16'hF800, 16'h4000);
      close_out();
   end
endmodule : keypad_scan_control_tb
